// ### pkg/bmfifo_pkg.sv
`default_nettype none
package bmfifo_pkg;
   // Storage word and port part widths, default depth and offset width
   localparam int WORD_W = 36;
   localparam int HALF_W = 18;
   localparam int BYTE_W = 9;
   localparam int DEPTH_DEF = 1024;
   localparam int DEF_OFS_W = 10;
   // Width select codes {bus match, write width, read width}
   localparam logic [2:0] WCFG_36_18 = 3'h4;
   localparam logic [2:0] WCFG_36_9 = 3'h5;
   localparam logic [2:0] WCFG_18_36 = 3'h6;
   localparam logic [2:0] WCFG_9_36 = 3'h7;
   // Default offsets indexed by {load select, sel1, sel0}
   localparam logic [DEF_OFS_W-1:0] DEF_OFS [8] = '{
      10'h007, 10'h00f, 10'h01f, 10'h03f, 10'h07f, 10'h0ff, 10'h1ff, 10'h3ff};
   // Register byte addresses
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_OFFSET = 8'h08;
   // Control register fields
   localparam int CTRL_PRS_BIT = 0;
   // Status and offset register fields
   localparam int ST_EMPTY = 0;
   localparam int ST_FULL = 1;
   localparam int ST_HALF = 2;
   localparam int ST_AE = 3;
   localparam int ST_AF = 4;
   localparam int ST_FALL_THROUGH_MODE = 5;
   localparam int ST_OVALID = 6;
   localparam int ST_COUNT = 8;
   localparam int OFS_AF_POS = 16;
   // Options caught during master reset
   typedef struct packed {
      logic fall_through_mode;
      logic sync_flags;
      logic rm_normal;
      logic little;
      logic ip;
      logic [2:0] wcfg;
   } bmfifo_cfg_t;
   localparam bmfifo_cfg_t CFG_RESET = '0;
endpackage : bmfifo_pkg

// ### design/bmfifo_top.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Fall-through: after first word, reader holds read enable low per further word.
// - Fall-through select caught at master reset picks standard or fall-through timing.
// - Fall-through flags allow chaining outputs to next buffer inputs without glue.
// - Empty/full in standard, ready flags in fall-through; half and almost flags always.
// - Master reset picks one of eight default offsets from two selects and load.
// - Serial enable plus load select shifts one serial bit per write edge.
// - Write enable plus load select loads offsets from the data input bus.
// - Read enable plus load select presents offsets on the data outputs.
// - Master reset zeroes both pointers and catches the timing mode.
// - Partial reset zeroes pointers, keeps mode and offsets, flags follow.
// - Asynchronous flag timing: almost flags follow the level at once.
// - Synchronous flag timing: almost flags change only on their own side edge.
// - Flag timing select is caught at master reset.
// - Retransmit request low moves the read pointer back to location zero.
// - Retransmit latency select caught at master reset; low means zero latency.
// - Zero latency retransmit loads the first word on the requesting edge.
// - Bus match and width selects set write and read port widths.
// - Big-endian: most significant part of a long word comes out first.
// - Little-endian: least significant part of a long word comes out first.
// - Interspersed parity drops D8, D17, D26, D35 from parallel offsets.
// - Non-interspersed parity uses D8, D17, D26 and ignores D32 to D35.
// - Parity placement never alters buffered data.
// - Byte order select low means big-endian, high little-endian.
// - Fall-through: first word appears on outputs without read enable.
module bmfifo_top #(
   parameter int DEPTH = bmfifo_pkg::DEPTH_DEF
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Write port
   input wire logic [35:0] data_in_bus,
   input wire logic wen_n,
   input wire logic serial_load_enable_n,
   input wire logic offset_load_select_n,
   input wire logic fall_through_select_serial_in,
   // Read port
   output logic [35:0] data_out_bus,
   input wire logic ren_n,
   input wire logic retransmit_request_n,
   // Resets and straps
   input wire logic master_reset_n,
   input wire logic partial_reset_n,
   input wire logic flag_timing_select,
   input wire logic retransmit_latency_select,
   input wire logic byte_order_select,
   input wire logic parity_position_select,
   input wire logic bus_match_select,
   input wire logic write_width_select,
   input wire logic read_width_select,
   input wire logic default_offset_sel0,
   input wire logic default_offset_sel1,
   // Flags
   output logic empty_or_out_valid_n,
   output logic full_or_space_avail_n,
   output logic half_level_flag_n,
   output logic almost_empty_flag_n,
   output logic almost_full_flag_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam int AW = $clog2(DEPTH);
   // Depth must be a power of two the pointers can wrap on
   if (DEPTH < 1024 || DEPTH > (1 << 22) || (1 << AW) != DEPTH) begin : g_depth_bad
      $error("DEPTH must be a power of two from 1024 to 4M");
   end

   ////////////////////////////////////////////////////////////////////
   // Part selection helpers
   function automatic logic [35:0] get_part(input logic [35:0] w, input logic [2:0] n,
                                             input logic [1:0] k, input logic le);
      logic [1:0] seg;
      logic [35:0] r;
      seg = le ? k : (n[1:0] - 2'h1 - k);
      case (n)
         3'h2: r = {18'h0, w[int'(seg[0]) * bmfifo_pkg::HALF_W +: bmfifo_pkg::HALF_W]};
         3'h4: r = {27'h0, w[int'(seg) * bmfifo_pkg::BYTE_W +: bmfifo_pkg::BYTE_W]};
         default: r = w;
      endcase
      return r;
   endfunction : get_part

   function automatic logic [35:0] put_part(input logic [35:0] w, input logic [35:0] d,
                                             input logic [2:0] n, input logic [1:0] k, input logic le);
      logic [1:0] seg;
      logic [35:0] r;
      seg = le ? k : (n[1:0] - 2'h1 - k);
      r = w;
      case (n)
         3'h2: r[int'(seg[0]) * bmfifo_pkg::HALF_W +: bmfifo_pkg::HALF_W] = d[17:0];
         3'h4: r[int'(seg) * bmfifo_pkg::BYTE_W +: bmfifo_pkg::BYTE_W] = d[8:0];
         default: r = d;
      endcase
      return r;
   endfunction : put_part

   ////////////////////////////////////////////////////////////////////
   // State
   bmfifo_pkg::bmfifo_cfg_t cfg;
   logic [35:0] mem [DEPTH];
   logic [AW:0] wptr, rptr;
   logic [1:0] pk_idx, up_idx;
   logic [35:0] pk_word;
   logic out_valid;
   logic [AW-1:0] ae_off, af_off;
   logic ofs_wsel, ofs_rsel;
   logic ae_q, af_q;
   logic soft_prs;

   ////////////////////////////////////////////////////////////////////
   // Decode of resets, widths and requests
   wire master_reset = ~master_reset_n;
   wire partial_reset = ~master_reset & (~partial_reset_n | soft_prs);
   wire [2:0] in_parts = (cfg.wcfg == bmfifo_pkg::WCFG_18_36) ? 3'h2 :
                         (cfg.wcfg == bmfifo_pkg::WCFG_9_36) ? 3'h4 : 3'h1;
   wire [2:0] out_parts = (cfg.wcfg == bmfifo_pkg::WCFG_36_18) ? 3'h2 :
                          (cfg.wcfg == bmfifo_pkg::WCFG_36_9) ? 3'h4 : 3'h1;
   wire [AW:0] count = wptr - rptr;
   wire empty = (count == '0);
   wire full = (count == (AW+1)'(DEPTH));
   wire quiet = ~master_reset & ~partial_reset;
   wire ofs_ser = quiet & ~serial_load_enable_n & ~offset_load_select_n;
   wire ofs_par = quiet & ~wen_n & ~offset_load_select_n;
   wire ofs_rd = quiet & ~ren_n & ~offset_load_select_n;
   wire wr_ok = quiet & ~wen_n & offset_load_select_n & ~full;
   wire pk_last = (pk_idx == 2'(in_parts - 3'h1));
   wire push = wr_ok & pk_last;
   wire [35:0] next_word = put_part(pk_word, data_in_bus, in_parts, pk_idx, cfg.little);
   wire rt = quiet & ~retransmit_request_n;
   wire rt_zero = rt & ~cfg.rm_normal & (wptr != '0);
   wire rd_std = ~cfg.fall_through_mode & ~ren_n & offset_load_select_n & ~empty;
   wire ld_fall_through_mode = cfg.fall_through_mode & offset_load_select_n & ~empty & (~out_valid | ~ren_n);
   wire drop_fall_through_mode = cfg.fall_through_mode & ~ren_n & offset_load_select_n & out_valid & empty;
   wire pop_part = quiet & ~rt & (rd_std | ld_fall_through_mode);
   wire up_last = (up_idx == 2'(out_parts - 3'h1));
   wire pop = pop_part & up_last;
   wire [35:0] head = mem[rptr[AW-1:0]];
   wire [35:0] first = mem[0];
   wire first_last = (out_parts == 3'h1);
   // Parallel offset value with parity bits stripped or ignored
   wire [31:0] ofs_bits = cfg.ip ? {data_in_bus[34:27], data_in_bus[25:18], data_in_bus[16:9],
                                    data_in_bus[7:0]} : data_in_bus[31:0];
   wire [AW-1:0] ofs_val = ofs_bits[AW-1:0];
   wire [AW-1:0] ofs_out = ofs_rsel ? af_off : ae_off;
   wire [31:0] ofs_out_ext = 32'(ofs_out);
   wire [35:0] ofs_gap = {1'b0, ofs_out_ext[31:24], 1'b0, ofs_out_ext[23:16], 1'b0,
                          ofs_out_ext[15:8], 1'b0, ofs_out_ext[7:0]};
   wire [31:0] ofs_spread = cfg.ip ? ofs_gap[35:4] : ofs_out_ext; // Gap word shifted right 4
   wire [2:0] def_idx = {offset_load_select_n, default_offset_sel1, default_offset_sel0};
   wire [AW-1:0] def_ofs = AW'(bmfifo_pkg::DEF_OFS[def_idx]);
   // Flag conditions in whole stored words
   wire ae_cond = (count <= (AW+1)'(ae_off));
   wire af_cond = (count >= ((AW+1)'(DEPTH) - (AW+1)'(af_off)));

   ////////////////////////////////////////////////////////////////////
   // Options caught while master reset is held
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg <= bmfifo_pkg::CFG_RESET;
      end else if (master_reset) begin
         cfg <= '{fall_through_mode: fall_through_select_serial_in, sync_flags: flag_timing_select,
                  rm_normal: retransmit_latency_select, little: byte_order_select,
                  ip: parity_position_select,
                  wcfg: {bus_match_select, write_width_select, read_width_select}};
      end
   end

   // Write pointer and input packing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wptr <= '0;
         pk_idx <= '0;
         pk_word <= '0;
      end else if (master_reset | partial_reset) begin
         wptr <= '0;
         pk_idx <= '0;
      end else if (wr_ok) begin
         pk_word <= next_word;
         pk_idx <= pk_last ? 2'h0 : pk_idx + 2'h1;
         if (push) begin
            wptr <= wptr + (AW+1)'(1);
         end
      end
   end

   // Storage array
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= next_word;
      end
   end

   // Read pointer, unpacking and output register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rptr <= '0;
         up_idx <= '0;
         out_valid <= 1'b0;
         data_out_bus <= '0;
      end else if (master_reset | partial_reset) begin
         rptr <= '0;
         up_idx <= '0;
         out_valid <= 1'b0;
      end else if (ofs_rd) begin
         data_out_bus <= {4'h0, ofs_spread};
      end else if (rt_zero) begin
         data_out_bus <= get_part(first, out_parts, 2'h0, cfg.little);
         rptr <= first_last ? (AW+1)'(1) : '0;
         up_idx <= first_last ? 2'h0 : 2'h1;
         out_valid <= cfg.fall_through_mode;
      end else if (rt) begin
         rptr <= '0;
         up_idx <= '0;
         out_valid <= 1'b0;
      end else if (pop_part) begin
         data_out_bus <= get_part(head, out_parts, up_idx, cfg.little);
         up_idx <= up_last ? 2'h0 : up_idx + 2'h1;
         out_valid <= cfg.fall_through_mode;
         if (pop) begin
            rptr <= rptr + (AW+1)'(1);
         end
      end else if (drop_fall_through_mode) begin
         out_valid <= 1'b0;
      end
   end

   // Offset registers: defaults, serial and parallel loading
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ae_off <= '0;
         af_off <= '0;
         ofs_wsel <= 1'b0;
      end else if (master_reset) begin
         ae_off <= def_ofs;
         af_off <= def_ofs;
         ofs_wsel <= 1'b0;
      end else if (ofs_ser) begin
         {af_off, ae_off} <= {fall_through_select_serial_in, af_off, ae_off[AW-1:1]};
      end else if (ofs_par) begin
         ofs_wsel <= ~ofs_wsel;
         if (ofs_wsel) begin
            af_off <= ofs_val;
         end else begin
            ae_off <= ofs_val;
         end
      end
   end

   // Offset read-back alternates almost-empty then almost-full
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ofs_rsel <= 1'b0;
      end else if (master_reset) begin
         ofs_rsel <= 1'b0;
      end else if (ofs_rd) begin
         ofs_rsel <= ~ofs_rsel;
      end
   end

   // Registered almost flags for synchronous flag timing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ae_q <= 1'b1;
         af_q <= 1'b0;
      end else begin
         ae_q <= ae_cond;
         af_q <= af_cond;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Flag outputs; ready flags are active low so they chain directly
   assign empty_or_out_valid_n = cfg.fall_through_mode ? ~out_valid : ~empty;
   assign full_or_space_avail_n = cfg.fall_through_mode ? full : ~full;
   assign half_level_flag_n = ~(count > (AW+1)'(DEPTH / 2));
   assign almost_empty_flag_n = cfg.sync_flags ? ~ae_q : ~ae_cond;
   assign almost_full_flag_n = cfg.sync_flags ? ~af_q : ~af_cond;

   ////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped addresses
   wire apb_hit = (paddr == bmfifo_pkg::ADDR_STATUS) | (paddr == bmfifo_pkg::ADDR_CTRL) |
                  (paddr == bmfifo_pkg::ADDR_OFFSET);
   wire apb_setup = psel & ~penable;
   wire apb_wr = psel & penable & pwrite & (paddr == bmfifo_pkg::ADDR_CTRL);
   wire [31:0] status_word = (32'(count) << bmfifo_pkg::ST_COUNT) |
                             (32'(out_valid) << bmfifo_pkg::ST_OVALID) |
                             (32'(cfg.fall_through_mode) << bmfifo_pkg::ST_FALL_THROUGH_MODE) |
                             (32'(!almost_full_flag_n) << bmfifo_pkg::ST_AF) |
                             (32'(!almost_empty_flag_n) << bmfifo_pkg::ST_AE) |
                             (32'(!half_level_flag_n) << bmfifo_pkg::ST_HALF) |
                             (32'(full) << bmfifo_pkg::ST_FULL) |
                             (32'(empty) << bmfifo_pkg::ST_EMPTY);
   wire [31:0] offset_word = (32'(af_off) << bmfifo_pkg::OFS_AF_POS) | 32'(ae_off);
   wire [31:0] rd_mux = (paddr == bmfifo_pkg::ADDR_STATUS) ? status_word :
                        (paddr == bmfifo_pkg::ADDR_OFFSET) ? offset_word : 32'h0;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~apb_hit;

   // Read data captured in setup; soft partial reset is a one-cycle pulse
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata <= '0;
         soft_prs <= 1'b0;
      end else begin
         if (apb_setup) begin
            prdata <= rd_mux;
         end
         soft_prs <= apb_wr & pwdata[bmfifo_pkg::CTRL_PRS_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_full_write_block: assert property (full & ~master_reset & ~partial_reset |=> $stable(wptr))
      else $error("write accepted while full");
   a_empty_read_block: assert property (~cfg.fall_through_mode & empty & quiet & ~rt |=> rptr == $past(rptr))
      else $error("read accepted while empty");
   a_retx_ptr_zero: assert property (rt & ~rt_zero & ~ofs_rd |=> rptr == '0)
      else $error("retransmit did not rewind");
   a_zero_lat_word: assert property (rt_zero & ~ofs_rd & first_last |=>
                                     data_out_bus == $past(first) && rptr == (AW+1)'(1))
      else $error("zero latency retransmit word wrong");
   a_mrs_ptrs_zero: assert property (master_reset |=> wptr == '0 && rptr == '0 && !out_valid)
      else $error("master reset left pointers");
   a_prs_keep_ofs: assert property (partial_reset |=> $stable(ae_off) && $stable(af_off) && $stable(cfg))
      else $error("partial reset changed settings");
   a_ser_shift_bit: assert property (ofs_ser |=> af_off[AW-1] == $past(fall_through_select_serial_in))
      else $error("serial bit not shifted in");
   a_strap_hold: assert property (~master_reset |=> $stable(cfg))
      else $error("options changed outside master reset");
   a_fall_through_mode_first: assert property (cfg.fall_through_mode & ~out_valid & ~empty & quiet & ~rt & ~ofs_rd
                                  & offset_load_select_n |=> out_valid)
      else $error("first word did not fall through");
   a_ofs_readback: assert property (ofs_rd & ~cfg.ip |=> data_out_bus == 36'($past(ofs_out)))
      else $error("offset read-back wrong");
endmodule : bmfifo_top
`default_nettype wire

// ### tb/bmfifo_writer_model.sv
`timescale 1ns/1ps
`default_nettype none
// Writer side logic: pushes n words counting up from base, one per edge
module bmfifo_writer_model (
   // Clock
   input wire logic mclk,
   // Command from the bench
   input wire logic go,
   input wire logic ofs,
   input wire logic [35:0] base,
   input wire logic [11:0] n,
   // Write port of the buffer
   output logic [35:0] data_in_bus,
   output logic wen_n,
   output logic offset_load_select_n,
   output logic busy
);
   logic [11:0] left = 12'h000;
   initial begin
      data_in_bus = 36'h000000000;
      wen_n = 1'b1;
      offset_load_select_n = 1'b1;
      busy = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // Write enable, with load select for offset words
   always @(posedge mclk) begin
      if (go && !busy) begin
         left <= n;
         data_in_bus <= base;
         wen_n <= 1'b0;
         offset_load_select_n <= !ofs;
         busy <= 1'b1;
      end else if (busy && left == 12'h001) begin
         wen_n <= 1'b1;
         offset_load_select_n <= 1'b1;
         data_in_bus <= ~data_in_bus; // Released bus shows no stale word
         busy <= 1'b0;
      end else if (busy) begin
         left <= left - 12'h001;
         data_in_bus <= data_in_bus + 36'h000000001;
      end
   end
endmodule : bmfifo_writer_model
`default_nettype wire

// ### tb/test_bus_matching_dual_clock_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module test_bus_matching_dual_clock_fifo;
   localparam logic [35:0] W = 36'h123456789;
   localparam logic [35:0] B = 36'h900000100;
   localparam logic [19:0] SER = 20'h55400;
   logic mclk = 1'b0, rstn = 1'b0, ren_n = 1'b1, retx_n = 1'b1, mreset_n = 1'b1, r_ld_n = 1'b1;
   logic [1:0] fsel = 2'h0;
   logic [7:0] strap = 8'h00;
   logic sen_n = 1'b1;
   logic go = 1'b0, ofs = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [35:0] base = 36'h000000000;
   logic [11:0] n = 12'h001;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic [35:0] din, dout;
   logic wen_n, w_ld_n, busy, empty_n, full_n, half_n, alm_e_n, alm_f_n, pready, pslverr, e;
   int err_total = 0, check_count = 0;
   wire logic ld_n = w_ld_n & r_ld_n;
   always #10 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////
   // Design and writer partner
   bmfifo_top dut (.mclk(mclk), .rstn(rstn), .data_in_bus(din), .wen_n(wen_n),
      .serial_load_enable_n(sen_n), .offset_load_select_n(ld_n),
      .fall_through_select_serial_in(strap[5]), .data_out_bus(dout), .ren_n(ren_n),
      .retransmit_request_n(retx_n), .master_reset_n(mreset_n), .partial_reset_n(1'b1),
      .flag_timing_select(strap[6]), .retransmit_latency_select(strap[4]), .byte_order_select(strap[3]),
      .parity_position_select(strap[7]), .bus_match_select(strap[2]), .write_width_select(strap[1]),
      .read_width_select(strap[0]), .default_offset_sel0(fsel[0]), .default_offset_sel1(fsel[1]),
      .empty_or_out_valid_n(empty_n), .full_or_space_avail_n(full_n), .half_level_flag_n(half_n),
      .almost_empty_flag_n(alm_e_n), .almost_full_flag_n(alm_f_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   bmfifo_writer_model writer (.mclk(mclk), .go(go), .ofs(ofs), .base(base), .n(n),
      .data_in_bus(din), .wen_n(wen_n), .offset_load_select_n(w_ld_n), .busy(busy));
   ////////////////////////////////////////////////////////////////
   // Comparison and verdict
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////
   // Access tasks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && t < 50) begin
         @(posedge mclk);
         t++;
      end
      if (t >= 50) begin
         err_total++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic push(input logic [35:0] b, input logic [11:0] k, input logic o);
      @(posedge mclk);
      base <= b;
      n <= k;
      ofs <= o;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      #1;
      for (int t = 0; t < 3000 && busy; t++) begin
         @(posedge mclk);
         #1;
      end
      if (busy) begin
         err_total++;
      end
   endtask : push
   task automatic rd(input logic ld);
      @(posedge mclk);
      ren_n <= 1'b0;
      r_ld_n <= !ld;
      @(posedge mclk);
      ren_n <= 1'b1;
      r_ld_n <= 1'b1;
      #1;
   endtask : rd
   task automatic mreset(input logic [7:0] s);
      @(posedge mclk);
      mreset_n <= 1'b0;
      strap <= s;
      repeat (2) @(posedge mclk);
      mreset_n <= 1'b1;
      @(posedge mclk);
   endtask : mreset
   ////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         r_ld_n <= i[2];
         fsel <= i[1:0];
         mreset(6'h00);
         r_ld_n <= 1'b1;
         apb(1'b0, bmfifo_pkg::ADDR_OFFSET, 32'h0);
         chk(q, {6'h00, bmfifo_pkg::DEF_OFS[i], 6'h00, bmfifo_pkg::DEF_OFS[i]});
      end
      fsel <= 2'h0;
      mreset(6'h00);
      chk({empty_n, full_n, half_n, alm_e_n, alm_f_n}, 5'b01101);
      push(B, 12'd10, 1'b0);
      chk({empty_n, full_n, half_n, alm_e_n, alm_f_n}, 5'b11101);
      apb(1'b0, bmfifo_pkg::ADDR_STATUS, 32'h0);
      chk(q[bmfifo_pkg::ST_COUNT +: 11], 11'd10);
      for (int j = 0; j < 3; j++) begin
         rd(1'b0);
         chk(dout, B + j);
      end
      // Zero latency retransmit
      @(posedge mclk);
      retx_n <= 1'b0;
      @(posedge mclk);
      retx_n <= 1'b1;
      #1 chk(dout, B);
      rd(1'b0);
      chk(dout, B + 1);
      // Partial reset through the control register
      apb(1'b1, bmfifo_pkg::ADDR_CTRL, 32'h1);
      repeat (2) @(posedge mclk);
      apb(1'b0, bmfifo_pkg::ADDR_STATUS, 32'h0);
      chk(q[bmfifo_pkg::ST_COUNT +: 11], 11'd0);
      chk({empty_n, full_n, half_n, alm_e_n, alm_f_n}, 5'b01101);
      apb(1'b0, bmfifo_pkg::ADDR_OFFSET, 32'h0);
      chk(q, 32'h007f007f);
      apb(1'b0, 8'h0c, 32'h0);
      chk(e, 1'b1);
      rd(1'b0);
      chk(dout, B + 1);
      // Parallel offset load and offset read back
      push(36'h000000120, 12'd2, 1'b1);
      apb(1'b0, bmfifo_pkg::ADDR_OFFSET, 32'h0);
      chk(q, 32'h01210120);
      apb(1'b0, bmfifo_pkg::ADDR_STATUS, 32'h0);
      chk(q[bmfifo_pkg::ST_COUNT +: 11], 11'd0);
      rd(1'b1);
      chk(dout[9:0], 10'h120);
      rd(1'b1);
      chk(dout[9:0], 10'h121);
      // Overfill: extra words refused
      push(36'h000000000, 12'd1030, 1'b0);
      chk({empty_n, full_n, half_n, alm_e_n, alm_f_n}, 5'b10010);
      apb(1'b0, bmfifo_pkg::ADDR_STATUS, 32'h0);
      chk(q[bmfifo_pkg::ST_COUNT +: 11], 11'd1024);
      rd(1'b0);
      chk(dout, 36'h000000000);
      chk(full_n, 1'b1);
      // Narrow read and narrow write, both byte orders
      for (int k = 0; k < 4; k++) begin
         mreset({2'b00, k[0], 1'b1, k[1], 1'b1});
         if (k[1]) begin
            push(36'h000000011, 12'd4, 1'b0);
            rd(1'b0);
            chk(dout, k[0] ? {9'h014, 9'h013, 9'h012, 9'h011} : {9'h011, 9'h012, 9'h013, 9'h014});
         end else begin
            push(W, 12'd1, 1'b0);
            for (int j = 0; j < 4; j++) begin
               rd(1'b0);
               chk(dout, k[0] ? W[9*j +: 9] : W[35-9*j -: 9]);
            end
         end
      end
      // Serial offsets, then registered almost-empty lags one edge
      mreset(8'h40);
      for (int b = 0; b < 20; b++) begin
         @(posedge mclk);
         sen_n <= 1'b0;
         r_ld_n <= 1'b0;
         strap[5] <= SER[b];
      end
      @(posedge mclk);
      sen_n <= 1'b1;
      r_ld_n <= 1'b1;
      apb(1'b0, bmfifo_pkg::ADDR_OFFSET, 32'h0);
      chk(q, 32'h01550000);
      push(W, 12'd1, 1'b0);
      chk(alm_e_n, 1'b0);
      @(posedge mclk);
      #1 chk(alm_e_n, 1'b1);
      // Fall-through timing, interspersed parity
      mreset(8'ha0);
      chk(full_n, 1'b0);
      push(36'h500000001, 12'd2, 1'b0);
      for (int t = 0; t < 10 && empty_n !== 1'b0; t++) begin
         @(posedge mclk);
         #1;
      end
      chk(empty_n, 1'b0);
      chk(dout, 36'h500000001);
      rd(1'b0);
      chk(dout, 36'h500000002);
      rd(1'b0);
      chk(empty_n, 1'b1);
      push(36'h000000501, 12'd2, 1'b1);
      apb(1'b0, bmfifo_pkg::ADDR_OFFSET, 32'h0);
      chk(q, 32'h02020201);
      report_and_stop();
   end
   // Watchdog against a hang
   initial begin
      #(20 * 20000);
      err_total++;
      report_and_stop();
   end
endmodule : test_bus_matching_dual_clock_fifo
`default_nettype wire
